// >>> src/burst_pwm_pkg.sv
// Constants, register map and timing counts for the burst density-modulated pin driver.
// Assumes a single 20 MHz system clock and a plain strobed register port.
// Overview of operation
// [R1] When a burst starts, the selected pin becomes a driven output and stays driven to the end.
// [R2] The pin selector covers pins 0 to 15, or only pins 0 to 7 on the smallest model.
// [R3] An unsigned 8-bit duty value from 0 to 255 sets the average output level.
// [R4] An unsigned 8-bit cycle count from 0 to 255 sets how many PWM cycles the burst lasts.
// [R5] Each PWM cycle lasts 5 ms, 1 ms, 0.4 ms, 0.65 ms or 1.62 ms depending on the model.
// [R6] Over each cycle the fraction of high time equals the duty value divided by 255; the code starts every burst with one low 1.6 us slot.
// [R7] The output is a fast irregular train of pulses as short as 1.6 us, not one on and one off.
// [R8] After the last cycle the pin direction bit is cleared so the filter keeps its charge.
// [R9] Density comes from adding the duty to an 8-bit accumulator per slot, high on carry-out; the code goes high at a sum of 255 or more and subtracts 255.
package burst_pwm_pkg;
    localparam int clk_period_ns = 50;
    localparam int slot_time_ns = 1600;
    localparam int slot_clks = slot_time_ns / clk_period_ns;
    localparam logic [7:0] duty_full = 8'hff;
    // Cycle units in microseconds, indexed by model: smallest, basic, then faster variants.
    localparam int unit_us_small = 5000;
    localparam int unit_us_basic = 1000;
    localparam int unit_us_fast_a = 400;
    localparam int unit_us_fast_b = 650;
    localparam int unit_us_fast_c = 1620;
    localparam int model_small = 0;

    // Register byte addresses.
    localparam logic [7:0] addr_control = 8'h00;
    localparam logic [7:0] addr_duty = 8'h04;
    localparam logic [7:0] addr_cycles = 8'h08;
    localparam logic [7:0] addr_status = 8'h0c;
    localparam logic [7:0] addr_direction = 8'h10;
    // Field positions.
    localparam int ctl_go_bit = 0;
    localparam int ctl_sel_lsb = 4;
    localparam int sts_busy_bit = 0;
    localparam int sts_left_lsb = 8;
    // Reset values.
    localparam logic [7:0] duty_reset = 8'h00;
    localparam logic [7:0] cycles_reset = 8'h00;
    localparam logic [3:0] sel_reset = 4'h0;

    typedef enum logic {st_idle, st_burst} burst_state_t;

    function automatic int unit_clks(input int model);
        int us;
        us = unit_us_basic;
        case (model)
            0: us = unit_us_small;
            2: us = unit_us_fast_a;
            3: us = unit_us_fast_b;
            4: us = unit_us_fast_c;
            default: us = unit_us_basic;
        endcase
        return (us * 1000) / clk_period_ns;
    endfunction
endpackage

// >>> src/density_if.sv
// Link between the burst sequencer and its pulse density generator.
// Assumes both ends share sys_clk.
`timescale 1ns/100ps
interface density_if;
    logic clear;
    logic tick;
    logic [7:0] duty;
    logic level;
    modport gen (input clear, input tick, input duty, output level);
    modport ctl (output clear, output tick, output duty, input level);
endinterface

// >>> src/density_gen.sv
// Pulse density generator: one accumulator step per pulse slot.
// Assumes tick is a one-cycle pulse at the slot rate and clear precedes each burst.
`timescale 1ns/100ps
module density_gen (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Sequencer side
    density_if.gen dens
);
    logic [7:0] acc;
    logic [8:0] sum;

    // Modulo-255 rather than 256 so that 255 slots give exactly duty ones.
    assign sum = {1'b0, acc} + {1'b0, dens.duty}; // R9

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            acc <= 8'h00;
            dens.level <= 1'b0;
        end else if (dens.clear) begin
            acc <= 8'h00;
            dens.level <= 1'b0;
        end else if (dens.tick) begin
            if (sum >= {1'b0, burst_pwm_pkg::duty_full}) begin // R6 R9
                acc <= 8'(sum - {1'b0, burst_pwm_pkg::duty_full});
                dens.level <= 1'b1;
            end else begin
                acc <= sum[7:0];
                dens.level <= 1'b0;
            end
        end
    end

    a_acc_bound: assert property (@(posedge sys_clk) disable iff (reset)
        acc != 8'hff) else $error("accumulator reached 255"); // R9
    a_full_duty_high: assert property (@(posedge sys_clk) disable iff (reset)
        dens.tick && !dens.clear && dens.duty == 8'hff |=> dens.level)
        else $error("full duty gave a low slot"); // R6
    a_zero_duty_low: assert property (@(posedge sys_clk) disable iff (reset)
        dens.tick && !dens.clear && dens.duty == 8'h00 |=> !dens.level)
        else $error("zero duty gave a high slot"); // R3
    a_slot_steps: assert property (@(posedge sys_clk) disable iff (reset)
        $changed(dens.level) |-> $past(dens.tick) || $past(dens.clear))
        else $error("level moved between slots"); // R7
endmodule // density_gen

// >>> src/burst_pwm_pin_output.sv
// Burst sequencer: registers, cycle timing and pin ownership for a density-modulated burst.
// Assumes a strobed register port on sys_clk and an RC filter on the chosen pin.
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/100ps
module burst_pwm_pin_output #(
    parameter int model = 1,
    parameter int unit_clocks = burst_pwm_pkg::unit_clks(model)
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Pins
    output logic [15:0] pin_out,
    output logic [15:0] pin_direction_bits
);
    burst_pwm_pkg::burst_state_t state;
    logic [3:0] pin_sel;
    logic [7:0] duty;
    logic [7:0] cycles;
    logic [7:0] cycles_left;
    logic [4:0] slot_cnt;
    logic [16:0] unit_cnt;
    logic go;
    logic slot_end;
    logic unit_end;
    logic [3:0] next_sel;
    density_if dens ();

    density_gen u_gen (
        .sys_clk(sys_clk),
        .reset(reset),
        .dens(dens.gen)
    );

    localparam logic [4:0] slot_last = 5'(burst_pwm_pkg::slot_clks - 1);
    localparam logic [16:0] unit_last = 17'(unit_clocks - 1);

    assign go = reg_write && reg_addr == burst_pwm_pkg::addr_control
        && reg_wdata[burst_pwm_pkg::ctl_go_bit];
    assign slot_end = state == burst_pwm_pkg::st_burst && slot_cnt == slot_last;
    assign unit_end = state == burst_pwm_pkg::st_burst && unit_cnt == unit_last;
    assign dens.clear = go && state == burst_pwm_pkg::st_idle;
    assign dens.tick = slot_end; // R7
    assign dens.duty = duty;

    // The smallest model has only eight pins, so the top selector bit is dropped.
    always_comb begin
        next_sel = reg_wdata[burst_pwm_pkg::ctl_sel_lsb +: 4];
        if (model == burst_pwm_pkg::model_small) begin
            next_sel[3] = 1'b0; // R2
        end
    end

    // Settings are frozen while a burst runs so the pin cannot move mid-burst.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pin_sel <= burst_pwm_pkg::sel_reset;
            duty <= burst_pwm_pkg::duty_reset;
            cycles <= burst_pwm_pkg::cycles_reset;
        end else if (reg_write && state == burst_pwm_pkg::st_idle) begin
            case (reg_addr)
                burst_pwm_pkg::addr_control: pin_sel <= next_sel; // R2
                burst_pwm_pkg::addr_duty: duty <= reg_wdata[7:0]; // R3
                burst_pwm_pkg::addr_cycles: cycles <= reg_wdata[7:0]; // R4
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= burst_pwm_pkg::st_idle;
            cycles_left <= 8'h00;
        end else begin
            case (state)
                burst_pwm_pkg::st_idle: begin
                    if (go && cycles != 8'h00) begin
                        state <= burst_pwm_pkg::st_burst;
                        cycles_left <= cycles; // R4
                    end
                end
                burst_pwm_pkg::st_burst: begin
                    if (unit_end) begin
                        cycles_left <= cycles_left - 8'h01; // R4
                        if (cycles_left == 8'h01) begin
                            state <= burst_pwm_pkg::st_idle;
                        end
                    end
                end
                default: state <= burst_pwm_pkg::st_idle;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            slot_cnt <= 5'h00;
            unit_cnt <= 17'h00000;
        end else if (state != burst_pwm_pkg::st_burst) begin
            slot_cnt <= 5'h00;
            unit_cnt <= 17'h00000;
        end else begin
            slot_cnt <= slot_end ? 5'h00 : slot_cnt + 5'h01; // R7
            unit_cnt <= unit_end ? 17'h00000 : unit_cnt + 17'h00001; // R5
        end
    end

    // The driver is released in the same edge that ends the burst.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pin_direction_bits <= 16'h0000;
            pin_out <= 16'h0000;
        end else if (state == burst_pwm_pkg::st_burst && !(unit_end && cycles_left == 8'h01)) begin
            pin_direction_bits <= 16'h0001 << pin_sel; // R1
            pin_out <= {15'h0000, dens.level} << pin_sel; // R6
        end else begin
            pin_direction_bits <= 16'h0000; // R8
            pin_out <= 16'h0000;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_read) begin
            case (reg_addr)
                burst_pwm_pkg::addr_control: reg_rdata <= {24'h000000, pin_sel, 4'h0};
                burst_pwm_pkg::addr_duty: reg_rdata <= {24'h000000, duty};
                burst_pwm_pkg::addr_cycles: reg_rdata <= {24'h000000, cycles};
                burst_pwm_pkg::addr_status: reg_rdata <= {16'h0000, cycles_left, 7'h00,
                    state == burst_pwm_pkg::st_burst};
                burst_pwm_pkg::addr_direction: reg_rdata <= {16'h0000, pin_direction_bits};
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    a_pin_driven: assert property (@(posedge sys_clk) disable iff (reset)
        $past(state == burst_pwm_pkg::st_burst) && state == burst_pwm_pkg::st_burst
        |-> pin_direction_bits == (16'h0001 << pin_sel))
        else $error("selected pin not driven during burst"); // R1
    a_pin_released: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(state == burst_pwm_pkg::st_burst) |-> pin_direction_bits == 16'h0000)
        else $error("pin still driven after burst"); // R8
    a_small_sel: assert property (@(posedge sys_clk) disable iff (reset)
        model == burst_pwm_pkg::model_small |-> !pin_sel[3])
        else $error("selector above pin 7 on small model"); // R2
    a_cycle_count: assert property (@(posedge sys_clk) disable iff (reset)
        unit_end |=> cycles_left == $past(cycles_left) - 8'h01)
        else $error("cycle count not stepped"); // R4
    a_burst_start: assert property (@(posedge sys_clk) disable iff (reset)
        state == burst_pwm_pkg::st_idle && go && cycles != 8'h00
        |=> state == burst_pwm_pkg::st_burst && cycles_left == $past(cycles) ##1
        pin_direction_bits != 16'h0000)
        else $error("burst did not start"); // R1
    a_unit_gap: assert property (@(posedge sys_clk) disable iff (reset)
        unit_end |=> !unit_end [*8])
        else $error("cycle unit too short"); // R5
endmodule // burst_pwm_pin_output

// >>> dv/rc_filter_model.sv
// RC filter model on the selected pin, plus counters of what it was charged with.
// Assumes the bench pulses clear before each burst and holds sel through it.
`timescale 1ns/100ps
module rc_filter_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Bench side
    input wire logic clear,
    input wire logic [3:0] sel,
    // Pins
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_en,
    // Counters
    output int high_clks,
    output int drive_clks,
    output int toggles,
    output int max_run
);
    logic cap;
    logic wire_lvl;
    int run;
    // A released pin shows the held capacitor level, which is the last level driven, not pin_out.
    assign wire_lvl = pin_en[sel] ? pin_out[sel] : cap;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset || clear) begin
            cap <= 1'b0;
            high_clks <= 0;
            drive_clks <= 0;
            toggles <= 0;
            max_run <= 0;
            run <= 0;
        end else if (pin_en[sel]) begin
            cap <= wire_lvl;
            drive_clks <= drive_clks + 1;
            high_clks <= high_clks + int'(wire_lvl);
            toggles <= toggles + int'(wire_lvl != cap);
            run <= wire_lvl ? run + 1 : 0;
            if (wire_lvl && run + 1 > max_run) begin
                max_run <= run + 1;
            end
        end
    end
endmodule // rc_filter_model

// >>> dv/tb_top.sv
// Self-checking bench for the burst pin driver, a small-model copy and the filter model.
// Assumes unit_clocks of 64 and the 32-clock slot of the package.
`timescale 1ns/100ps
module tb_top;
    logic sys_clk, reset, reg_write, reg_read, clr;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_s, d;
    logic [15:0] pin_out, dir, out_s, dir_s;
    logic [3:0] msel;
    int hi, drv, tog, mrun, error_cnt, tests_run;
    // Both copies share the register port, so the small one sees the same selector.
    burst_pwm_pin_output #(.model(1), .unit_clocks(64)) dut (.sys_clk(sys_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_direction_bits(dir));
    burst_pwm_pin_output #(.model(0), .unit_clocks(64)) dut_small (.sys_clk(sys_clk),
        .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(rd_s), .pin_out(out_s), .pin_direction_bits(dir_s));
    rc_filter_model rc (.sys_clk(sys_clk), .reset(reset), .clear(clr), .sel(msel),
        .pin_out(pin_out), .pin_en(dir), .high_clks(hi), .drive_clks(drv), .toggles(tog),
        .max_run(mrun));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_rng(input string n, input int lo, input int hi_b, input int g);
        tests_run++;
        if (g < lo || g > hi_b) begin
            error_cnt++;
            $display("ERROR %s expected %0d..%0d seen %0d", n, lo, hi_b, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        @(posedge sys_clk);
        v = reg_rdata;
    endtask
    task go(input logic [7:0] duty, input logic [7:0] cyc, input logic [3:0] s);
        wr(burst_pwm_pkg::addr_duty, {24'h0, duty});
        wr(burst_pwm_pkg::addr_cycles, {24'h0, cyc});
        msel <= s;
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        wr(burst_pwm_pkg::addr_control, {24'h0, s, 4'h1});
        repeat (3) @(posedge sys_clk);
    endtask
    task wait_idle;
        for (int i = 0; i < 20000 && dir !== 16'h0; i++) @(posedge sys_clk);
        @(posedge sys_clk);
    endtask
    task conclude;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        error_cnt++;
        conclude();
    end
    initial begin
        {reset, reg_write, reg_read, clr, reg_addr, reg_wdata, msel} = '0;
        error_cnt = 0;
        tests_run = 0;
        reset = 1'b1;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        rd(burst_pwm_pkg::addr_status, d);
        chk("status", 32'h0, d);
        rd(8'h20, d);
        chk("unmapped", 32'h0, d);
        go(8'hff, 8'h02, 4'hf);
        chk("dir", 32'h8000, {16'h0, dir});
        chk("dir_small", 32'h0080, {16'h0, dir_s});
        chk("pin_out", 32'h0, {16'h0, pin_out & ~dir});
        rd(burst_pwm_pkg::addr_status, d);
        chk("busy", 32'h1, {31'h0, d[burst_pwm_pkg::sts_busy_bit]});
        chk("left", 32'h2, {24'h0, d[burst_pwm_pkg::sts_left_lsb +: 8]});
        rd(burst_pwm_pkg::addr_direction, d);
        chk("dir_reg", 32'h8000, d);
        chk("dir_reg_small", 32'h0080, rd_s);
        chk("pin_out_small", 32'h0, {16'h0, out_s & ~dir_s});
        wr(burst_pwm_pkg::addr_duty, 32'h0);
        wr(burst_pwm_pkg::addr_control, 32'h31);
        chk("dir_busy", 32'h8000, {16'h0, dir});
        wait_idle();
        chk_rng("drive_clks", 127, 128, drv);
        chk_rng("high_full", drv - 40, drv, hi);
        chk("dir_end", 32'h0, {16'h0, dir});
        rd(burst_pwm_pkg::addr_duty, d);
        chk("duty_kept", 32'hff, d);
        rd(burst_pwm_pkg::addr_control, d);
        chk("control", 32'hf0, d);
        go(8'h00, 8'h01, 4'h3);
        chk("dir_pin3", 32'h0008, {16'h0, dir});
        wait_idle();
        chk("high_zero", 32'h0, hi);
        chk_rng("drive_one", 63, 64, drv);
        go(8'h64, 8'h00, 4'h2);
        chk("no_burst", 32'h0, {16'h0, dir});
        go(8'h64, 8'h80, 4'h0);
        wait_idle();
        chk_rng("high_100", 99 * 32, 102 * 32, hi);
        chk_rng("max_run", 1, 32, mrun);
        chk_rng("toggles", 180, 210, tog);
        chk("dir_final", 32'h0, {16'h0, dir});
        conclude();
    end
endmodule // tb_top
